// ---- common/asr_defs.svh ----
// timing constants for the host-side async sram controller
// assumes a 10 MHz system clock (100 ns period)
`ifndef ASR_DEFS_SVH
`define ASR_DEFS_SVH
`define ASR_CLK_NS        100
`define ASR_ADDR_W        10
`define ASR_DATA_W        4
`define ASR_ADDR_RST      10'h000
`define ASR_DATA_RST      4'h0
`define ASR_CYCLE_NS      200
`define ASR_CYCLE_CYC     ((`ASR_CYCLE_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`define ASR_WPULSE_NS     120
`define ASR_WPULSE_CYC    ((`ASR_WPULSE_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`define ASR_ACCESS_NS     200
`define ASR_ACCESS_CYC    ((`ASR_ACCESS_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`define ASR_RELEASE_NS    60
`define ASR_RELEASE_CYC   ((`ASR_RELEASE_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`endif

// ---- common/asr_pkg.sv ----
// types for the host-side async sram controller
// assumes asr_defs.svh is on the include path
`include "asr_defs.svh"
package asr_pkg;
   typedef struct packed
   {
      logic                   write;
      logic [`ASR_ADDR_W-1:0] addr;
      logic [`ASR_DATA_W-1:0] data;
   } asr_req_t;
   typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_WSET, ST_WPULSE, ST_GAP} asr_state_t;
endpackage

// ---- hw/asr_host.sv ----
// host controller that runs read and write cycles on a 1k x 4 async sram
// assumes one 10 MHz clock, synchronous reset, memory pins driven directly
`timescale 1ns/100ps
`include "asr_defs.svh"
// Functional notes
// RULE1: memory is 1024 words of 4 bits
// RULE2: select low, strobe high reads
// RULE3: select and strobe low writes
// RULE4: simultaneous falls keep memory outputs off
// RULE5: memory releases bus after deselect
// RULE6: memory releases bus after strobe falls
// RULE7: read valid access time after address
// RULE8: read valid 70 ns after select
// RULE9: memory drives no sooner than 20 ns
// RULE10: old data held 50 ns after address
// RULE11: host holds address one cycle time
// RULE12: host holds strobe low 120 ns
// RULE13: write data set up before strobe rises
// RULE14: address may change at strobe rise
// RULE15: read returns last written value
// RULE16: host never drives bus during read
module asr_host
(
   input  wire logic                   clock,
   input  wire logic                   rst,
   input  wire asr_pkg::asr_req_t      req,
   input  wire logic                   reqValid,
   output logic                        reqReady,
   output logic [`ASR_DATA_W-1:0]      rdData,
   output logic                        rdValid,
   output logic [`ASR_ADDR_W-1:0]      memAddr,
   output logic                        memSelect_n,
   output logic                        memWrite_n,
   input  wire logic [`ASR_DATA_W-1:0] dataIn,
   output logic [`ASR_DATA_W-1:0]      dataOut,
   output logic                        dataOe
);
   localparam logic [2:0] CYCLE_CNT   = 3'(`ASR_CYCLE_CYC);
   localparam logic [2:0] WPULSE_CNT  = 3'(`ASR_WPULSE_CYC);
   localparam logic [2:0] ACCESS_CNT  = 3'(`ASR_ACCESS_CYC);
   localparam logic [2:0] RELEASE_CNT = 3'(`ASR_RELEASE_CYC);

   // sequencing state and the events it hands to the pin groups
   asr_pkg::asr_state_t    state_q, state_d;
   logic [2:0]             cnt_q, cnt_d;
   logic                   take;
   logic                   rdDone;
   logic                   wsetDone;
   logic                   wpDone;
   // memory pin state
   logic [`ASR_ADDR_W-1:0] addr_q, addr_d;
   logic [`ASR_DATA_W-1:0] wdata_q, wdata_d;
   logic                   sel_n_q, sel_n_d;
   logic                   wr_n_q, wr_n_d;
   logic                   oe_q, oe_d;
   // read result state
   logic [`ASR_DATA_W-1:0] rdata_q, rdata_d;
   logic                   rdv_q, rdv_d;

   ////////////////////////////////////////////////////////////////////////////////
   // one shared counter times every phase; whole clocks only, so each
   // phase is rounded up and never shorter than the memory asks
   always_comb
   begin
      state_d  = state_q;
      cnt_d    = cnt_q;
      take     = 1'h0;
      rdDone   = 1'h0;
      wsetDone = 1'h0;
      wpDone   = 1'h0;
      unique case (state_q)
         asr_pkg::ST_IDLE:
         begin
            if (reqValid)
            begin
               take  = 1'h1;
               cnt_d = 3'h1;
               // RULE16: writes wait out a release time before driving
               if (req.write)
                  state_d = asr_pkg::ST_WSET;
               else
                  state_d = asr_pkg::ST_READ;
            end
         end
         asr_pkg::ST_READ:
         begin
            // RULE7: wait access and cycle time
            if (cnt_q >= ACCESS_CNT && cnt_q >= CYCLE_CNT)
            begin
               rdDone  = 1'h1;
               cnt_d   = 3'h1;
               state_d = asr_pkg::ST_GAP;
            end
            else
               cnt_d = cnt_q + 3'h1;
         end
         asr_pkg::ST_WSET:
         begin
            if (cnt_q >= RELEASE_CNT)
            begin
               wsetDone = 1'h1;
               cnt_d    = 3'h1;
               state_d  = asr_pkg::ST_WPULSE;
            end
            else
               cnt_d = cnt_q + 3'h1;
         end
         asr_pkg::ST_WPULSE:
         begin
            if (cnt_q >= WPULSE_CNT)
            begin
               wpDone  = 1'h1;
               cnt_d   = 3'h1;
               state_d = asr_pkg::ST_GAP;
            end
            else
               cnt_d = cnt_q + 3'h1;
         end
         asr_pkg::ST_GAP:
         begin
            // RULE5: let memory release after deselect
            // RULE11: address held full cycle overall
            if (cnt_q >= RELEASE_CNT)
               state_d = asr_pkg::ST_IDLE;
            else
               cnt_d = cnt_q + 3'h1;
         end
         // unused state codes fall back to idle
         default:
         begin
            state_d = asr_pkg::ST_IDLE;
            cnt_d   = 3'h0;
         end
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state_q <= asr_pkg::ST_IDLE;
         cnt_q   <= 3'h0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      addr_d  = addr_q;
      wdata_d = wdata_q;
      sel_n_d = sel_n_q;
      wr_n_d  = wr_n_q;
      oe_d    = oe_q;
      if (take)
      begin
         addr_d  = req.addr;
         wdata_d = req.data;
         sel_n_d = 1'h0;
         // RULE2: read with strobe high
         // RULE4: strobe falls with select
         wr_n_d  = ~req.write;
      end
      if (rdDone)
         sel_n_d = 1'h1;
      // RULE6: memory outputs off by now
      if (wsetDone)
         oe_d = 1'h1;
      // RULE12: strobe low long enough
      // RULE13: data set up before rise
      if (wpDone)
      begin
         // RULE3: write ends on strobe rise
         // data is dropped on the same edge, relying on zero hold
         wr_n_d  = 1'h1;
         sel_n_d = 1'h1;
         oe_d    = 1'h0;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         addr_q  <= `ASR_ADDR_RST;
         wdata_q <= `ASR_DATA_RST;
         sel_n_q <= 1'h1;
         wr_n_q  <= 1'h1;
         oe_q    <= 1'h0;
      end
      else
      begin
         addr_q  <= addr_d;
         wdata_q <= wdata_d;
         sel_n_q <= sel_n_d;
         wr_n_q  <= wr_n_d;
         oe_q    <= oe_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // the bus is captured on the edge that deselects, while it still stands
   always_comb
   begin
      rdata_d = rdata_q;
      rdv_d   = 1'h0;
      if (rdDone)
      begin
         rdata_d = dataIn;
         rdv_d   = 1'h1;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         rdata_q <= `ASR_DATA_RST;
         rdv_q   <= 1'h0;
      end
      else
      begin
         rdata_q <= rdata_d;
         rdv_q   <= rdv_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   assign reqReady    = (state_q == asr_pkg::ST_IDLE);
   assign rdData      = rdata_q;
   assign rdValid     = rdv_q;
   // RULE14: address moves only from idle
   assign memAddr     = addr_q;
   assign memSelect_n = sel_n_q;
   assign memWrite_n  = wr_n_q;
   assign dataOut     = wdata_q;
   assign dataOe      = oe_q;
endmodule

// ---- tb/asr_mem_model.sv ----
// behavioural 1k x 4 sram on the far side of the host controller
// assumes host pins wired straight in; the shared bus level is resolved here
`timescale 1ns/100ps
`include "asr_defs.svh"
module asr_mem_model
(
   input  wire logic [`ASR_ADDR_W-1:0] memAddr,
   input  wire logic                   memSelect_n,
   input  wire logic                   memWrite_n,
   input  wire logic [`ASR_DATA_W-1:0] dataOut,
   input  wire logic                   dataOe,
   output logic      [`ASR_DATA_W-1:0] busLevel
);
   logic [`ASR_DATA_W-1:0] mem [1024];
   logic [`ASR_DATA_W-1:0] lastQ = 4'h5;
   logic [`ASR_DATA_W-1:0] rdWord;
   wire                    rdOn;
   // drive window, no glitch on joint fall
   assign #(20,60) rdOn = !memSelect_n && memWrite_n;
   // word settles late, old one stays meanwhile
   always @(memAddr, memSelect_n, memWrite_n, dataOe, dataOut)
   begin
      if (!memSelect_n && !memWrite_n && dataOe)
         mem[memAddr] = dataOut;
      rdWord <= #70 mem[memAddr];
   end
   always @* if (rdOn) lastQ = rdWord;
   // released bus shows the inverse so stale data never passes
   // both sides driving shows as unknown
   assign busLevel = (dataOe && rdOn) ? 4'hX : dataOe ? dataOut : rdOn ? rdWord : ~lastQ;
endmodule

// ---- tb/asr_host_checker.sv ----
// pin assertions for the host sram controller
// assumes bound onto asr_host, one clock domain
`timescale 1ns/100ps
`include "asr_defs.svh"
module asr_host_checker
(
   input  wire logic                   clock,
   input  wire logic                   rst,
   input  wire logic                   rdValid,
   input  wire logic [`ASR_ADDR_W-1:0] memAddr,
   input  wire logic                   memSelect_n,
   input  wire logic                   memWrite_n,
   input  wire logic                   dataOe
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence wrStart; $fell(memWrite_n); endsequence
   sequence rdStart; $fell(memSelect_n) && memWrite_n; endsequence
   AST_WR_TOGETHER: assert property (wrStart |-> $fell(memSelect_n))
      else $error("strobe fell apart from select");
   AST_WR_PULSE: assert property (wrStart |-> (!memWrite_n)[*3])
      else $error("write pulse short");
   AST_WR_SEL: assert property (!memWrite_n |-> !memSelect_n)
      else $error("strobe without select");
   AST_RD_QUIET: assert property (!memSelect_n && memWrite_n |-> !dataOe)
      else $error("host drives during read");
   AST_OE_WAIT: assert property (wrStart |-> !dataOe ##1 dataOe[*2] ##1 !dataOe)
      else $error("write data timing");
   AST_SETUP: assert property ($rose(memWrite_n) |-> $past(dataOe, 2) && $rose(memSelect_n))
      else $error("data setup or end");
   AST_RD_ANSWER: assert property (rdStart |-> ##2 rdValid)
      else $error("read answer late");
   AST_ADDR_HOLD: assert property ($changed(memAddr) |=> $stable(memAddr))
      else $error("address held short");
   AST_RD_PULSE: assert property (rdValid |=> !rdValid)
      else $error("read pulse long");
endmodule
bind asr_host asr_host_checker u_chk
(
   .clock       (clock),
   .rst         (rst),
   .rdValid     (rdValid),
   .memAddr     (memAddr),
   .memSelect_n (memSelect_n),
   .memWrite_n  (memWrite_n),
   .dataOe      (dataOe)
);

// ---- tb/async_sram_1k_by_4_test.sv ----
// self-checking bench for the host sram controller
// assumes the behavioural sram model on the far side
`timescale 1ns/100ps
`include "asr_defs.svh"
module async_sram_1k_by_4_test;
   logic                   clock = 0, rst = 1, reqValid = 0;
   logic                   reqReady, rdValid, memSelect_n, memWrite_n, dataOe;
   asr_pkg::asr_req_t      req = '0;
   logic [`ASR_DATA_W-1:0] rdData, dataIn, dataOut;
   logic [`ASR_ADDR_W-1:0] memAddr;
   int                     error_cnt = 0, total_checks = 0, cycles = 0;
   always #50 clock = ~clock;
   asr_host u_dut
   (
      .clock       (clock),
      .rst         (rst),
      .req         (req),
      .reqValid    (reqValid),
      .reqReady    (reqReady),
      .rdData      (rdData),
      .rdValid     (rdValid),
      .memAddr     (memAddr),
      .memSelect_n (memSelect_n),
      .memWrite_n  (memWrite_n),
      .dataIn      (dataIn),
      .dataOut     (dataOut),
      .dataOe      (dataOe)
   );
   asr_mem_model u_mem
   (
      .memAddr     (memAddr),
      .memSelect_n (memSelect_n),
      .memWrite_n  (memWrite_n),
      .dataOut     (dataOut),
      .dataOe      (dataOe),
      .busLevel    (dataIn)
   );
   task automatic final_report;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         error_cnt++;
         $display("ERROR %0t timeout", $time);
         final_report;
      end
   end
   task automatic chk(input logic [4:0] got, exp);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %0t read %h want %h", $time, got, exp);
      end
   endtask
   task automatic chkPin(input logic [11:0] got, exp);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %0t pins %h want %h", $time, got, exp);
      end
   endtask
   task automatic chkCnt(input logic [3:0] got, exp);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %0t ready after %0d want %0d", $time, got, exp);
      end
   endtask
   task automatic op(input logic w, input logic [9:0] a, input logic [3:0] d);
      logic [3:0] n;
      @(negedge clock);
      req = '{w, a, d};
      reqValid = 1'h1;
      @(negedge clock);
      reqValid = 1'h0;
      chkPin({memSelect_n, memWrite_n, memAddr}, {1'h0, ~w, a});
      repeat (2) @(negedge clock);
      if (w)
         chkPin({7'h00, dataOe, dataOut}, {7'h00, 1'h1, d});
      else
         chk({rdValid, rdData}, {1'h1, d});
      n = 4'h3;
      while (reqReady !== 1'h1 && n < 4'h9)
      begin
         @(negedge clock);
         n++;
      end
      chkCnt(n, w ? 4'h5 : 4'h4);
   endtask
   task automatic test_reset;
      @(negedge clock);
      req = '{1'h1, 10'h00C, 4'h7};
      reqValid = 1'h1;
      @(negedge clock);
      reqValid = 1'h0;
      rst = 1'h1;
      repeat (3) @(negedge clock);
      rst = 1'h0;
      chkPin({memSelect_n, memWrite_n, memAddr}, {2'h3, `ASR_ADDR_RST});
      chkPin({8'h00, dataOe, rdValid, reqReady, 1'h0}, {8'h00, 4'h2});
      op(0, 10'h005, 4'hC);
      $display("test_reset done");
   endtask
   task automatic test_fill;
      logic [9:0] a [4] = '{10'h000, 10'h3FF, 10'h155, 10'h2AA};
      foreach (a[i]) op(1, a[i], 4'(i + 9));
      foreach (a[i]) op(0, a[i], 4'(i + 9));
      $display("test_fill done");
   endtask
   task automatic test_overwrite;
      op(1, 10'h005, 4'h3);
      op(1, 10'h005, 4'hC);
      op(0, 10'h005, 4'hC);
      $display("test_overwrite done");
   endtask
   task automatic test_refuse;
      op(1, 10'h00A, 4'h2);
      @(negedge clock);
      req = '{1'b1, 10'h009, 4'h6};
      reqValid = 1;
      @(negedge clock);
      req = '{1'b1, 10'h00A, 4'hF};
      repeat (3) @(negedge clock);
      reqValid = 0;
      repeat (9) if (reqReady !== 1'b1) @(negedge clock);
      op(0, 10'h00A, 4'h2);
      op(0, 10'h009, 4'h6);
      $display("test_refuse done");
   endtask
   initial
   begin
      repeat (3) @(negedge clock);
      rst = 0;
      test_fill;
      test_overwrite;
      test_refuse;
      test_reset;
      final_report;
   end
endmodule
